// File: logic/uart_char_path.sv
// Character path of one asynchronous serial channel: receive and
// transmit FIFOs, line format, line status and a Wishbone slave.
// Assumes a classic Wishbone master on clk_i and an async serial line.
// Notes on behaviour
// - 64-entry receive and transmit FIFOs
// - FIFOs off: single character in entry zero
// - Full FIFO drops the extra character
// - Error flags stored with each character
// - Control bit 0 enables both FIFOs
// - Control bit 1 clears receive FIFO
// - Control bit 2 clears transmit FIFO
// - Bits 5:4 set transmit space trigger
// - Bits 7:6 set receive character trigger
// - Transmit trigger writable only when enhanced
// - Format bits 1:0 set character length
// - Format bit 2 sets stop length
// - Format bit 3 enables parity
// - Format bit 4 picks odd or even
// - Format bit 5 forces the parity value
// - Format bit 6 holds line low
// - Format bit 7 opens divisor latch
// - Status bits: data ready, overrun
// - Status 4:2 show head character flags
// - Status bits: holding empty, all empty
// - Status bit 7: flagged character present
// - Status read never advances read pointer
`timescale 1ns/1ps
module uart_char_path #(
   parameter int DEPTH = 64 // FIFO entries, a power of two
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [5:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic rx_i,
   output logic tx_o,
   output logic rx_dma_ready_o,
   output logic tx_dma_ready_o
);
   import uart_char_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

   // Whole module state
   typedef struct packed {
      logic ack;                       // Bus answer
      logic [7:0] rd_data;             // Registered read data
      logic [15:0] div;                // Divisor latch
      logic [7:0] line_format_control;                 // Line format
      logic fifo_en;
      logic dma_mode;
      logic [1:0] tx_trig;
      logic [1:0] rx_trig;
      logic efe;                       // Enhanced function enable
      logic overrun;
      logic [DEPTH-1:0][10:0] rx_mem;  // {break, framing, parity, data}
      logic [AW-1:0] rx_wp;
      logic [AW-1:0] rx_rp;
      logic [AW:0] rx_cnt;
      logic [AW:0] err_cnt;            // Flagged characters held
      logic [DEPTH-1:0][7:0] tx_mem;
      logic [AW-1:0] tx_wp;
      logic [AW-1:0] tx_rp;
      logic [AW:0] tx_cnt;
      logic [2:0] sync;                // Receive pin synchroniser
      logic line;                      // Filtered receive level
      logic line_prev;
      logic [15:0] baud_cnt;
      ser_state_e rx_st;
      logic [5:0] rx_tick;
      logic [2:0] rx_bit;
      logic [7:0] rx_sh;
      logic rx_par;
      ser_state_e tx_st;
      logic [5:0] tx_tick;
      logic [2:0] tx_bit;
      logic [7:0] tx_sh;
      logic tx_par;
      logic tx_line;
      logic rx_rdy;
      logic tx_rdy;
   } state_s;

   state_s s_reg;
   state_s s_next;

   // Data bits from the two length bits
   function automatic logic [2:0] last_bit(input logic [7:0] line_format_control);
      last_bit = {1'b1, line_format_control[1:0]}; // 4..7, last index is len-1
   endfunction : last_bit

   // Parity bit for a character under the current format
   function automatic logic par_bit(input logic [7:0] d, input logic [7:0] line_format_control);
      logic [7:0] m;
      m = d & (8'hFF >> (3'h3 - {1'b0, line_format_control[1:0]}));
      if (line_format_control[LF_PAR_FORCE]) begin
         par_bit = ~line_format_control[LF_PAR_EVEN];
      end else begin
         par_bit = line_format_control[LF_PAR_EVEN] ? ^m : ~^m;
      end
   endfunction : par_bit

   // Storage index: entry zero whenever the FIFOs are off
   function automatic logic [AW-1:0] idx(input logic en, input logic [AW-1:0] p);
      idx = en ? p : '0;
   endfunction : idx

   // Receive trigger in characters
   function automatic logic [6:0] rx_trig_lvl(input logic [1:0] t);
      unique case (t)
         2'h0: rx_trig_lvl = RX_TRIG_0;
         2'h1: rx_trig_lvl = RX_TRIG_1;
         2'h2: rx_trig_lvl = RX_TRIG_2;
         2'h3: rx_trig_lvl = RX_TRIG_3;
      endcase
   endfunction : rx_trig_lvl

   // Transmit trigger in free spaces
   function automatic logic [6:0] tx_trig_lvl(input logic [1:0] t);
      unique case (t)
         2'h0: tx_trig_lvl = TX_TRIG_0;
         2'h1: tx_trig_lvl = TX_TRIG_1;
         2'h2: tx_trig_lvl = TX_TRIG_2;
         2'h3: tx_trig_lvl = TX_TRIG_3;
      endcase
   endfunction : tx_trig_lvl

   // Next state of everything
   always_comb begin
      logic req;
      logic wr;
      logic rd;
      logic dlab;
      logic tick;
      logic [AW:0] limit;
      logic rx_push;
      logic [10:0] rx_entry;
      logic rx_pop;
      logic rx_clr;
      logic tx_push;
      logic tx_pop;
      logic tx_clr;
      logic [10:0] rx_head;
      logic [7:0] rx_data;
      logic [5:0] stop_ticks;
      logic [7:0] line_status;
      logic [6:0] free;
      req = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      dlab = 1'b0;
      tick = 1'b0;
      limit = '0;
      rx_push = 1'b0;
      rx_entry = '0;
      rx_pop = 1'b0;
      rx_clr = 1'b0;
      tx_push = 1'b0;
      tx_pop = 1'b0;
      tx_clr = 1'b0;
      rx_head = '0;
      rx_data = '0;
      stop_ticks = '0;
      line_status = '0;
      free = '0;
      s_next = s_reg;
      s_next.ack = 1'b0;

      // One answer per request, a cycle after it is seen
      req = cyc_i & stb_i & ~s_reg.ack;
      wr = req & we_i & sel_i[0];
      rd = req & ~we_i;
      dlab = s_reg.line_format_control[LF_DLAB];
      limit = s_reg.fifo_en ? DEPTH_C : (AW+1)'(1);
      rx_head = s_reg.rx_mem[idx(s_reg.fifo_en, s_reg.rx_rp)];
      if (req) begin
         s_next.ack = 1'b1;
      end

      // Pin synchroniser: the first stage feeds only the second
      s_next.sync = {s_reg.sync[1:0], rx_i};
      if (s_reg.sync[1] == s_reg.sync[2]) begin
         s_next.line = s_reg.sync[2];
      end
      s_next.line_prev = s_reg.line;

      // Sixteen-times bit rate enable from the divisor
      if (s_reg.baud_cnt + 16'h0001 >= s_reg.div) begin
         tick = 1'b1;
         s_next.baud_cnt = '0;
      end else begin
         s_next.baud_cnt = s_reg.baud_cnt + 16'h0001;
      end

      // Line status assembly
      line_status[0] = (s_reg.rx_cnt != '0);
      line_status[1] = s_reg.overrun;
      line_status[4:2] = line_status[0] ? rx_head[10:8] : 3'h0;
      line_status[5] = (s_reg.tx_cnt == '0);
      line_status[6] = line_status[5] && (s_reg.tx_st == SER_IDLE);
      line_status[7] = (s_reg.err_cnt != '0);

      // Register reads
      if (rd) begin
         s_next.rd_data = 8'h00; // Unmapped offsets read zero
         unique case (adr_i)
            OFS_HOLD: begin
               if (dlab) begin
                  s_next.rd_data = s_reg.div[7:0];
               end else begin
                  s_next.rd_data = rx_head[7:0];
                  rx_pop = line_status[0];
               end
            end
            OFS_DIV_HI: begin
               s_next.rd_data = dlab ? s_reg.div[15:8] : 8'h00;
            end
            OFS_LINE_FMT: s_next.rd_data = s_reg.line_format_control;
            OFS_LINE_STAT: begin
               // Pointer stays put; only overrun is cleared
               s_next.rd_data = line_status;
               s_next.overrun = 1'b0;
            end
            OFS_ENH: s_next.rd_data = {3'h0, s_reg.efe, 4'h0};
            default: s_next.rd_data = 8'h00;
         endcase
      end

      // Register writes, low byte lane only
      if (wr) begin
         unique case (adr_i)
            OFS_HOLD: begin
               if (dlab) begin
                  s_next.div[7:0] = dat_i[7:0];
               end else begin
                  tx_push = 1'b1;
               end
            end
            OFS_DIV_HI: begin
               if (dlab) begin
                  s_next.div[15:8] = dat_i[7:0];
               end
            end
            OFS_FIFO_CTRL: begin
               // Switching FIFO mode empties both to keep pointers sane
               if (dat_i[FC_EN] != s_reg.fifo_en) begin
                  rx_clr = 1'b1;
                  tx_clr = 1'b1;
               end
               s_next.fifo_en = dat_i[FC_EN];
               if (dat_i[FC_RX_CLR]) begin
                  rx_clr = 1'b1;
               end
               if (dat_i[FC_TX_CLR]) begin
                  tx_clr = 1'b1;
               end
               s_next.dma_mode = dat_i[FC_DMA];
               if (s_reg.efe) begin
                  s_next.tx_trig = dat_i[FC_TX_TRIG+:2];
               end
               s_next.rx_trig = dat_i[FC_RX_TRIG+:2];
            end
            OFS_LINE_FMT: s_next.line_format_control = dat_i[7:0];
            OFS_ENH: s_next.efe = dat_i[ENH_BIT];
            default: ;
         endcase
      end

      // Receiver, sampling mid-bit on the oversample enable
      rx_data = s_reg.rx_sh >> (3'h7 - last_bit(s_reg.line_format_control));
      unique case (s_reg.rx_st)
         SER_IDLE: begin
            // Falling edge of the start bit
            if (s_reg.line_prev && !s_reg.line) begin
               s_next.rx_st = SER_START;
               s_next.rx_tick = '0;
            end
         end
         SER_START: begin
            if (tick) begin
               s_next.rx_tick = s_reg.rx_tick + 6'h01;
               if (s_reg.rx_tick == TICKS_HALF - 6'h01) begin
                  // A short glitch is a false start
                  s_next.rx_st = s_reg.line ? SER_IDLE : SER_DATA;
                  s_next.rx_tick = '0;
                  s_next.rx_bit = '0;
               end
            end
         end
         SER_DATA, SER_PAR, SER_STOP: begin
            if (tick) begin
               s_next.rx_tick = s_reg.rx_tick + 6'h01;
               if (s_reg.rx_tick == TICKS_BIT - 6'h01) begin
                  s_next.rx_tick = '0;
                  if (s_reg.rx_st == SER_DATA) begin
                     s_next.rx_sh = {s_reg.line, s_reg.rx_sh[7:1]};
                     s_next.rx_bit = s_reg.rx_bit + 3'h1;
                     if (s_reg.rx_bit == last_bit(s_reg.line_format_control)) begin
                        s_next.rx_st = s_reg.line_format_control[LF_PAR_EN] ? SER_PAR : SER_STOP;
                     end
                  end else if (s_reg.rx_st == SER_PAR) begin
                     s_next.rx_par = s_reg.line;
                     s_next.rx_st = SER_STOP;
                  end else begin
                     // Stop sample: flags go into the entry with the byte
                     rx_push = 1'b1;
                     rx_entry[7:0] = rx_data;
                     rx_entry[10] = !s_reg.line && (rx_data == 8'h00)
                        && !(s_reg.line_format_control[LF_PAR_EN] && s_reg.rx_par);
                     rx_entry[9] = !s_reg.line;
                     rx_entry[8] = s_reg.line_format_control[LF_PAR_EN]
                        && (s_reg.rx_par != par_bit(rx_data, s_reg.line_format_control));
                     s_next.rx_st = SER_IDLE;
                  end
               end
            end
         end
         default: s_next.rx_st = SER_IDLE;
      endcase

      // Transmitter
      stop_ticks = TICKS_BIT;
      if (s_reg.line_format_control[LF_STOP]) begin
         stop_ticks = (s_reg.line_format_control[1:0] == 2'h0) ? TICKS_STOP15 : TICKS_STOP2;
      end
      unique case (s_reg.tx_st)
         SER_IDLE: begin
            if (s_reg.tx_cnt != '0) begin
               tx_pop = 1'b1;
               s_next.tx_sh = s_reg.tx_mem[idx(s_reg.fifo_en, s_reg.tx_rp)];
               s_next.tx_par = par_bit(s_next.tx_sh, s_reg.line_format_control);
               s_next.tx_st = SER_START;
               s_next.tx_tick = '0;
               s_next.tx_bit = '0;
            end
         end
         SER_START, SER_DATA, SER_PAR: begin
            if (tick) begin
               s_next.tx_tick = s_reg.tx_tick + 6'h01;
               if (s_reg.tx_tick == TICKS_BIT - 6'h01) begin
                  s_next.tx_tick = '0;
                  if (s_reg.tx_st == SER_START) begin
                     s_next.tx_st = SER_DATA;
                  end else if (s_reg.tx_st == SER_DATA) begin
                     s_next.tx_sh = {1'b0, s_reg.tx_sh[7:1]};
                     s_next.tx_bit = s_reg.tx_bit + 3'h1;
                     if (s_reg.tx_bit == last_bit(s_reg.line_format_control)) begin
                        s_next.tx_st = s_reg.line_format_control[LF_PAR_EN] ? SER_PAR : SER_STOP;
                     end
                  end else begin
                     s_next.tx_st = SER_STOP;
                  end
               end
            end
         end
         SER_STOP: begin
            if (tick) begin
               s_next.tx_tick = s_reg.tx_tick + 6'h01;
               if (s_reg.tx_tick == stop_ticks - 6'h01) begin
                  s_next.tx_st = SER_IDLE;
               end
            end
         end
         default: s_next.tx_st = SER_IDLE;
      endcase

      // Line level follows the next state; break overrides all
      unique case (s_next.tx_st)
         SER_START: s_next.tx_line = 1'b0;
         SER_DATA: s_next.tx_line = s_next.tx_sh[0];
         SER_PAR: s_next.tx_line = s_next.tx_par;
         default: s_next.tx_line = 1'b1;
      endcase
      if (s_reg.line_format_control[LF_BREAK]) begin
         s_next.tx_line = 1'b0;
      end

      // Receive FIFO update; a full FIFO drops and flags overrun
      if (rx_clr) begin
         s_next.rx_wp = '0;
         s_next.rx_rp = '0;
         s_next.rx_cnt = '0;
         s_next.err_cnt = '0;
      end else begin
         if (rx_push && s_reg.rx_cnt < limit) begin
            s_next.rx_mem[idx(s_reg.fifo_en, s_reg.rx_wp)] = rx_entry;
            s_next.rx_wp = idx(s_reg.fifo_en, s_reg.rx_wp + 1'b1);
         end
         if (rx_pop) begin
            s_next.rx_rp = idx(s_reg.fifo_en, s_reg.rx_rp + 1'b1);
         end
         s_next.rx_cnt = s_reg.rx_cnt
            + (AW+1)'(rx_push && s_reg.rx_cnt < limit) - (AW+1)'(rx_pop);
         s_next.err_cnt = s_reg.err_cnt
            + (AW+1)'(rx_push && s_reg.rx_cnt < limit && |rx_entry[10:8])
            - (AW+1)'(rx_pop && |rx_head[10:8]);
      end
      // Overrun set wins over the status-read clear
      if (rx_push && s_reg.rx_cnt >= limit) begin
         s_next.overrun = 1'b1;
      end

      // Transmit FIFO update; writes to a full FIFO are dropped
      if (tx_clr) begin
         s_next.tx_wp = '0;
         s_next.tx_rp = '0;
         s_next.tx_cnt = '0;
      end else begin
         if (tx_push && s_reg.tx_cnt < limit) begin
            s_next.tx_mem[idx(s_reg.fifo_en, s_reg.tx_wp)] = dat_i[7:0];
            s_next.tx_wp = idx(s_reg.fifo_en, s_reg.tx_wp + 1'b1);
         end
         if (tx_pop) begin
            s_next.tx_rp = idx(s_reg.fifo_en, s_reg.tx_rp + 1'b1);
         end
         s_next.tx_cnt = s_reg.tx_cnt
            + (AW+1)'(tx_push && s_reg.tx_cnt < limit) - (AW+1)'(tx_pop);
      end

      // DMA request levels; mode 1 uses the trigger tables
      free = 7'(limit - s_reg.tx_cnt);
      if (s_reg.dma_mode) begin
         s_next.rx_rdy = 7'(s_reg.rx_cnt) >= rx_trig_lvl(s_reg.rx_trig);
         s_next.tx_rdy = free >= tx_trig_lvl(s_reg.tx_trig);
      end else begin
         s_next.rx_rdy = (s_reg.rx_cnt != '0);
         s_next.tx_rdy = (s_reg.tx_cnt == '0);
      end
   end

   // State register; reset clears all else, memories included, but sets the divisor to one and sync, line levels and tx_rdy high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg <= '0;
         s_reg.div <= DIV_RST;
         s_reg.line_format_control <= LINE_FMT_RST;
         s_reg.sync <= 3'h7;
         s_reg.line <= 1'b1;
         s_reg.line_prev <= 1'b1;
         s_reg.tx_line <= 1'b1;
         s_reg.tx_rdy <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign dat_o = {24'h000000, s_reg.rd_data};
   assign ack_o = s_reg.ack;
   assign tx_o = s_reg.tx_line;
   assign rx_dma_ready_o = s_reg.rx_rdy;
   assign tx_dma_ready_o = s_reg.tx_rdy;
endmodule : uart_char_path

// File: shared/uart_char_pkg.sv
// Shared constants for the serial character path: register map,
// field positions, reset values, trigger tables and state encodings.
// Assumes a 32-bit Wishbone slave with byte addresses.
package uart_char_pkg;
   // Register byte offsets
   localparam logic [5:0] OFS_HOLD = 6'h00;      // Holding regs, or divisor low
   localparam logic [5:0] OFS_DIV_HI = 6'h04;    // Divisor high while latch open
   localparam logic [5:0] OFS_FIFO_CTRL = 6'h08; // Write only
   localparam logic [5:0] OFS_LINE_FMT = 6'h0C;
   localparam logic [5:0] OFS_LINE_STAT = 6'h14;
   localparam logic [5:0] OFS_ENH = 6'h20;       // Enhanced function enable
   // FIFO control bit positions
   localparam int FC_EN = 0;
   localparam int FC_RX_CLR = 1;
   localparam int FC_TX_CLR = 2;
   localparam int FC_DMA = 3;
   localparam int FC_TX_TRIG = 4;
   localparam int FC_RX_TRIG = 6;
   // Line format bit positions
   localparam int LF_STOP = 2;
   localparam int LF_PAR_EN = 3;
   localparam int LF_PAR_EVEN = 4;
   localparam int LF_PAR_FORCE = 5;
   localparam int LF_BREAK = 6;
   localparam int LF_DLAB = 7;
   localparam int ENH_BIT = 4;
   // Reset values
   localparam logic [7:0] LINE_FMT_RST = 8'h00;
   localparam logic [15:0] DIV_RST = 16'h0001;
   // Trigger tables
   localparam logic [6:0] TX_TRIG_0 = 7'h08;
   localparam logic [6:0] TX_TRIG_1 = 7'h10;
   localparam logic [6:0] TX_TRIG_2 = 7'h20;
   localparam logic [6:0] TX_TRIG_3 = 7'h38;
   localparam logic [6:0] RX_TRIG_0 = 7'h01;
   localparam logic [6:0] RX_TRIG_1 = 7'h04;
   localparam logic [6:0] RX_TRIG_2 = 7'h38;
   localparam logic [6:0] RX_TRIG_3 = 7'h3C;
   // Oversample ticks per bit and per stop length
   localparam logic [5:0] TICKS_BIT = 6'h10;
   localparam logic [5:0] TICKS_HALF = 6'h08;
   localparam logic [5:0] TICKS_STOP15 = 6'h18;
   localparam logic [5:0] TICKS_STOP2 = 6'h20;
   // Serial state machines
   typedef enum logic [2:0] {
      SER_IDLE = 3'b000,
      SER_START = 3'b001,
      SER_DATA = 3'b010,
      SER_PAR = 3'b011,
      SER_STOP = 3'b100
   } ser_state_e;
endpackage : uart_char_pkg

// File: bench/uart_char_path_monitor.sv
// Port checker for the serial character path.
// Assumes the divisor keeps its reset value of one.
`timescale 1ns/1ps
module uart_char_path_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [5:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic tx_o
);
   import uart_char_pkg::*;
   logic take; // Request taken at this edge
   logic [7:0] fmt_reg; // Mirror of software's line format
   logic rv_reg; // A read was taken last edge
   logic [5:0] ra_reg; // Its address
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   assign take = cyc_i && stb_i && !ack_o;
   // Mirror only byte lane 0 writes, as the design ignores the rest
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fmt_reg <= LINE_FMT_RST;
         rv_reg <= 1'b0;
         ra_reg <= 6'h00;
      end else begin
         if (take && we_i && sel_i[0] && adr_i == OFS_LINE_FMT) begin
            fmt_reg <= dat_i[7:0];
         end
         rv_reg <= take && !we_i;
         ra_reg <= adr_i;
      end
   end
   a_ack_next: assert property (take |=> ack_o) else $error("no acknowledge");
   a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("long acknowledge");
   a_fmt_back: assert property (ack_o && rv_reg && ra_reg == OFS_LINE_FMT
      |-> dat_o[7:0] == fmt_reg) else $error("format readback wrong");
   a_fctl_zero: assert property (ack_o && rv_reg && ra_reg == OFS_FIFO_CTRL
      |-> dat_o == 32'h0) else $error("control register readable");
   a_stat_empty: assert property (ack_o && rv_reg && ra_reg == OFS_LINE_STAT
      && dat_o[6] |-> dat_o[5]) else $error("all empty without holding empty");
   a_stat_flag: assert property (ack_o && rv_reg && ra_reg == OFS_LINE_STAT
      && |dat_o[4:2] |-> dat_o[7] && dat_o[0]) else $error("flag summary wrong");
   a_break_low: assert property (fmt_reg[LF_BREAK] && $past(fmt_reg[LF_BREAK])
      |-> !tx_o) else $error("break not driven");
   a_start_len: assert property ($fell(tx_o) && !fmt_reg[LF_BREAK]
      |-> !tx_o [*8]) else $error("short low bit");
endmodule : uart_char_path_monitor
bind uart_char_path uart_char_path_monitor mon_u (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
   .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .tx_o(tx_o));

// File: bench/uart_line_partner.sv
// Remote serial end: sends frames on the line, captures frames sent.
// Assumes a bit time of 16 clocks (divisor one).
`timescale 1ns/1ps
module uart_line_partner (
   input wire logic clk_i,
   input wire logic tx_i,
   output logic rx_o
);
   initial rx_o = 1'b1; // Idle line is high
   // Holds one level for n clocks
   task bit_out(input logic b, input int n);
      rx_o <= b;
      repeat (n) @(posedge clk_i);
   endtask : bit_out
   // Start, n data bits LSB first, parity if p>=0, stop level s
   task send(input logic [7:0] x, input int n, input int p, input logic s);
      @(posedge clk_i);
      bit_out(1'b0, 16);
      for (int i = 0; i < n; i++) bit_out(x[i], 16);
      if (p >= 0) bit_out(p[0], 16);
      bit_out(s, 16);
      bit_out(1'b1, 16); // Line high so a break ends cleanly
   endtask : send
   // Waits for a start edge (bounded), samples bits at their centres
   task recv(input int n, input int p, output logic [7:0] x, output logic pb,
      output logic ok);
      x = 8'h00;
      pb = 1'b0;
      ok = 1'b0;
      for (int k = 0; k < 4000 && !ok; k++) begin
         @(posedge clk_i);
         ok = (tx_i === 1'b0);
      end
      repeat (8) @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         repeat (16) @(posedge clk_i);
         x[i] = tx_i;
      end
      if (p != 0) begin
         repeat (16) @(posedge clk_i);
         pb = tx_i;
      end
      repeat (16) @(posedge clk_i);
      ok = ok && (tx_i === 1'b1); // Stop bit must be high
   endtask : recv
endmodule : uart_line_partner

// File: bench/tb.sv
// Self-checking bench: Wishbone register calls plus a remote line end.
// Assumes the design runs with its default divisor of one.
`timescale 1ns/1ps
module tb;
   import uart_char_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [5:0] adr_i = 6'h00;
   logic [3:0] sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0, dat_o;
   logic ack_o, rx_i, tx_o, rx_dma_ready_o, tx_dma_ready_o;
   int num_errors = 0, checked = 0;
   int trig[4] = '{1, 4, 56, 60}; // Receive trigger table
   logic [7:0] v, d, x; // Read data, captured char, sent char
   logic pb, ok;
   always #2 clk_i = ~clk_i; // 250 MHz
   uart_char_path #(.DEPTH(64)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .rx_i(rx_i), .tx_o(tx_o),
      .rx_dma_ready_o(rx_dma_ready_o), .tx_dma_ready_o(tx_dma_ready_o));
   uart_line_partner line_u (.clk_i(clk_i), .tx_i(tx_o), .rx_o(rx_i));
   // Verdict and end of run
   task stop_test;
      $display("checked %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // One classic cycle; held until ack is sampled, bounded wait
   task bus(input logic w, input logic [5:0] a, input logic [7:0] wd);
      int k;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h0, wd};
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 50);
      if (k >= 50) begin
         num_errors++;
         stop_test();
      end
      v = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i); // Idle cycle between requests
   endtask : bus
   task wr(input logic [5:0] a, input logic [7:0] wd);
      bus(1'b1, a, wd);
   endtask : wr
   task rd(input logic [5:0] a);
      bus(1'b0, a, 8'h00);
   endtask : rd
   // Parity bit for mode m = format bits 5:4
   function automatic logic par(input logic [7:0] q, input int m);
      case (m)
         0: return ~^q;
         1: return ^q;
         2: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : par
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i); // Let the receive sync settle
      rd(OFS_LINE_FMT); chk("fmt_rst", 8'h00, v);
      rd(OFS_LINE_STAT); chk("stat_rst", 8'h60, v);
      rd(OFS_FIFO_CTRL); chk("fctl_rd", 8'h00, v);
      wr(OFS_LINE_FMT, 8'h83); // Divisor latch open
      rd(OFS_HOLD); chk("div_lo", 8'h01, v);
      wr(OFS_FIFO_CTRL, 8'h01);
      // Each parity mode, receive good then bad, then transmit
      for (int m = 0; m < 4; m++) begin
         x = 8'h35 + 8'(m);
         wr(OFS_LINE_FMT, 8'h0A | 8'(m << 4));
         rd(OFS_LINE_FMT); chk("fmt", 8'h0A | m << 4, v);
         line_u.send(x, 7, int'(par(x, m)), 1'b1);
         // Logical not keeps the wrong parity one bit wide, never -1
         line_u.send(x, 7, int'(!par(x, m)), 1'b1);
         chk("rx_rdy0", 1, 32'(rx_dma_ready_o));
         rd(OFS_LINE_STAT); chk("st_head_ok", 8'hE1, v);
         rd(OFS_HOLD); chk("rx_good", x, v);
         rd(OFS_LINE_STAT); chk("st_pe", 8'hE5, v);
         rd(OFS_LINE_STAT); chk("st_again", 8'hE5, v);
         rd(OFS_HOLD); chk("rx_bad", x, v);
         rd(OFS_LINE_STAT); chk("st_clean", 8'h60, v);
         fork
            line_u.recv(7, 1, d, pb, ok);
            begin
               wr(OFS_HOLD, x);
               rd(OFS_LINE_STAT); chk("st_tx", 8'h20, v);
            end
         join
         chk("tx_frame", {1'b1, par(x, m), x}, {ok, pb, d});
      end
      wr(OFS_LINE_FMT, 8'h03);
      // Framing error, then break with zero data
      for (int j = 0; j < 2; j++) begin
         line_u.send(j ? 8'h00 : 8'h5A, 8, -1, 1'b0);
         rd(OFS_LINE_STAT); chk("st_fe_bi", j ? 8'hF9 : 8'hE9, v);
         rd(OFS_HOLD); chk("rx_fe_bi", j ? 8'h00 : 8'h5A, v);
      end
      wr(OFS_FIFO_CTRL, 8'h00); // Single entry mode
      wr(OFS_LINE_FMT, 8'h00);
      line_u.send(8'h11, 5, -1, 1'b1);
      line_u.send(8'h12, 5, -1, 1'b1);
      rd(OFS_LINE_STAT); chk("st_ovr1", 8'h63, v);
      rd(OFS_HOLD); chk("rx_first", 8'h11, v);
      rd(OFS_LINE_STAT); chk("st_empty", 8'h60, v);
      // Every receive trigger level in DMA mode 1, overfilled
      for (int c = 0; c < 4; c++) begin
         wr(OFS_FIFO_CTRL, 8'h0B | 8'(c << 6));
         rd(OFS_LINE_STAT); chk("rx_clr", 0, v[0]);
         for (int i = 0; i < 65; i++) begin
            line_u.send(8'(i), 5, -1, 1'b1);
            chk("rx_rdy", i + 1 >= trig[c], 32'(rx_dma_ready_o));
         end
      end
      rd(OFS_LINE_STAT); chk("st_full", 8'h63, v);
      for (int i = 0; i < 64; i++) begin
         rd(OFS_HOLD); chk("rx_fifo", i % 32, v);
      end
      rd(OFS_LINE_STAT); chk("st_drained", 8'h60, v);
      // Transmit space trigger: locked until enhanced enable is set
      for (int i = 0; i < 10; i++) wr(OFS_HOLD, 8'(i));
      wr(OFS_FIFO_CTRL, 8'h39);
      chk("tx_rdy_lock", 1, 32'(tx_dma_ready_o));
      wr(OFS_ENH, 8'h10);
      wr(OFS_FIFO_CTRL, 8'h39);
      chk("tx_rdy_56", 0, 32'(tx_dma_ready_o));
      wr(OFS_FIFO_CTRL, 8'h3D);
      rd(OFS_LINE_STAT); chk("tx_clr", 1, v[5]);
      wr(OFS_LINE_FMT, 8'h40);
      repeat (3) @(posedge clk_i);
      chk("tx_break", 0, 32'(tx_o));
      wr(OFS_LINE_FMT, 8'h00);
      stop_test();
   end
endmodule : tb
